/* File: logic/cfss_selector.sv */
// Top of the cooling fan speed selector for the heater, paper, writer, imaging-unit and rear fans.
// Assumes the machine flags come from the machine state controller on the same clock, so they are not
// synchronised, and that each fan driver accepts a stop, half or full command held steady between changes.
`timescale 1ns/1ps
module cfss_selector
    import cfss_pkg::*;
#(
    parameter int unsigned HOLD_LONG  = HOLD_LONG_CYCLES,
    parameter int unsigned HOLD_SHORT = HOLD_SHORT_CYCLES,
    parameter int unsigned KICK_LEN   = KICK_CYCLES
)
(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          ce,
    input  wire cfss_machine_t machine,
    output cfss_fan_cmd_t      fanCmd,
    output cfss_mode_t         machineMode,
    output logic               modeChanged
);

    generate
        if (HOLD_LONG == 0 || HOLD_SHORT == 0)
        begin : g_bad_hold
            $error("cfss_selector: hold times must be at least one cycle");
        end
    endgenerate

    cfss_mode_t mode_reg;
    cfss_mode_t mode_next;
    logic       modeChanged_reg;
    logic       modeChange;

    // Stops that apply to every fan, whatever door it watches.
    function automatic logic commonStop(input cfss_machine_t m);
        commonStop = m.powerSwitchOff | m.lowPower | m.sleep;
        commonStop = commonStop | m.fwUpdate;
        commonStop = commonStop | m.paperJam | m.trouble;
        commonStop = commonStop | m.drivesOff;
    endfunction

    function automatic logic runPhase(input cfss_machine_t m);
        runPhase = m.warmUp | m.initialOp | m.imageStab | m.printing;
    endfunction

    // Request for one fan; priority is settled in the fan drive, so the three bits may overlap here.
    function automatic cfss_req_t fanRequest(input int idx, input cfss_machine_t m);
        cfss_req_t r;
        r.stop = commonStop(m);
        r.full = runPhase(m);
        r.half = 1'b0;
        case (idx)
            FAN_PAPER:
            begin
                r.stop = r.stop | m.frontDoorOpen;
                r.full = r.full | m.beltClean;
                r.half = m.standby | m.frontDoorOpen;
            end
            FAN_WRITER:
            begin
                r.stop = r.stop | m.frontDoorOpen;
                r.half = m.standby;
            end
            FAN_IMAGING_UNIT:
            begin
                r.stop = r.stop | m.doorOpen | m.frontDoorOpen | m.standby;
                r.full = r.full | m.beltClean;
            end
            FAN_REAR:
            begin
                // Standby stays out of the stop set: with no request the fan stops anyway, yet a hold still runs.
                r.stop = r.stop | m.doorOpen | m.frontDoorOpen;
                r.full = r.full | m.beltClean;
            end
            default:
            begin
                r.stop = r.stop | m.doorOpen | m.frontDoorOpen;
                r.half = m.standby;
            end
        endcase
        return r;
    endfunction

    // The operating mode is a coarse summary of the flags; its changes start the full-speed holds.
    // Any common stop or open door counts as the halt mode, so a fault entered or left from another mode is also a change.
    always_comb
    begin
        if (commonStop(machine) || machine.doorOpen || machine.frontDoorOpen)
            mode_next = MODE_HALT;
        else if (machine.printing)
            mode_next = MODE_PRINT;
        else if (machine.beltClean)
            mode_next = MODE_BELTCLEAN;
        else if (runPhase(machine))
            mode_next = MODE_WARMUP;
        else if (machine.standby)
            mode_next = MODE_STANDBY;
        else
            mode_next = MODE_HALT;
    end

    assign modeChange = (mode_next != mode_reg);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            mode_reg <= MODE_RESET;
        else if (ce)
            mode_reg <= mode_next;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            modeChanged_reg <= 1'b0;
        else if (ce)
            modeChanged_reg <= modeChange;
    end

    // Hold lengths follow the fan groups; the paper and imaging-unit fans have none.
    function automatic int unsigned holdFor(input int idx, input int unsigned longHold,
                                            input int unsigned shortHold);
        case (idx)
            FAN_WRITER, FAN_REAR:             holdFor = longHold;
            FAN_HEATER_TWO, FAN_HEATER_THREE: holdFor = shortHold;
            default:                          holdFor = 0;
        endcase
    endfunction

    generate
        for (genvar i = 0; i < FAN_COUNT; i++)
        begin : g_fan
            cfss_fan_drive #(
                .HOLD_CYCLES (holdFor(i, HOLD_LONG, HOLD_SHORT)),
                .KICK_LEN    (KICK_LEN)
            ) u_drive (
                .clk        (clk),
                .resetn     (resetn),
                .ce         (ce),
                .req        (fanRequest(i, machine)),
                .modeChange (modeChange & ce),
                .speed      (fanCmd[i])
            );
        end
    endgenerate

    assign machineMode = mode_reg;
    assign modeChanged = modeChanged_reg;

endmodule

/* File: logic/cfss_pkg.sv */
// Package for the cooling fan speed selector: speed and mode types, machine flags and timing constants.
// Assumes a single 50 MHz system clock shared by the machine state controller and the fan drivers.
package cfss_pkg;

    typedef enum logic [1:0] {SPD_STOP, SPD_HALF, SPD_FULL} cfss_speed_t;

    typedef enum logic [2:0] {MODE_HALT, MODE_STANDBY, MODE_WARMUP, MODE_BELTCLEAN, MODE_PRINT} cfss_mode_t;

    // Machine state flags, all active high, driven by the machine state controller.
    typedef struct packed {
        logic powerSwitchOff;
        logic lowPower;
        logic sleep;
        logic fwUpdate;
        logic paperJam;
        logic trouble;
        logic doorOpen;
        logic frontDoorOpen;
        logic drivesOff;
        logic standby;
        logic warmUp;
        logic initialOp;
        logic imageStab;
        logic beltClean;
        logic printing;
    } cfss_machine_t;

    typedef struct packed {
        logic stop;
        logic full;
        logic half;
    } cfss_req_t;

    localparam int FAN_COUNT = 6;
    localparam int FAN_HEATER_TWO   = 0;
    localparam int FAN_HEATER_THREE = 1;
    localparam int FAN_PAPER        = 2;
    localparam int FAN_WRITER       = 3;
    localparam int FAN_IMAGING_UNIT = 4;
    localparam int FAN_REAR         = 5;

    typedef cfss_speed_t [FAN_COUNT-1:0] cfss_fan_cmd_t;

    localparam int    CNT_W          = 31;
    localparam longint CLK_HZ        = 50_000_000;
    localparam longint HOLD_LONG_S   = 30;
    localparam longint HOLD_SHORT_S  = 10;
    localparam longint KICK_MS       = 500;
    localparam int unsigned HOLD_LONG_CYCLES  = int'(HOLD_LONG_S * CLK_HZ);
    localparam int unsigned HOLD_SHORT_CYCLES = int'(HOLD_SHORT_S * CLK_HZ);
    localparam int unsigned KICK_CYCLES       = int'((KICK_MS * CLK_HZ) / 1000);

    localparam cfss_speed_t SPEED_RESET = SPD_STOP;
    localparam cfss_mode_t  MODE_RESET  = MODE_HALT;

endpackage

/* File: logic/cfss_fan_drive.sv */
// One fan's speed command: priority of requests, full-speed hold after a mode change, start-up kick.
// Assumes requests and the mode-change pulse come from logic on the same clock.
`timescale 1ns/1ps
module cfss_fan_drive
    import cfss_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = 0,
    parameter int unsigned KICK_LEN    = KICK_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire cfss_req_t   req,
    input  wire logic        modeChange,
    output cfss_speed_t      speed
);

    generate
        if (KICK_LEN == 0 || KICK_LEN >= (32'h8000_0000) || HOLD_CYCLES >= (32'h8000_0000))
        begin : g_bad
            $error("cfss_fan_drive: counts must fit the counter and the kick must be at least one cycle");
        end
    endgenerate

    cfss_speed_t      speed_reg;
    cfss_speed_t      speed_next;
    logic [CNT_W-1:0] holdCnt_reg;
    logic [CNT_W-1:0] kickCnt_reg;
    logic             loadHold;
    logic             loadKick;

    // The hold starts only for a fan that was already at full speed when the mode moved on.
    assign loadHold = (HOLD_CYCLES != 0) && modeChange && (speed_reg == SPD_FULL);

    always_comb
    begin
        loadKick = 1'b0;
        if (req.stop)
            speed_next = SPD_STOP;
        else if (req.full || loadHold || holdCnt_reg != '0)
            speed_next = SPD_FULL;
        else if (req.half)
        begin
            if (speed_reg == SPD_STOP)
            begin
                speed_next = SPD_FULL;
                loadKick   = 1'b1;
            end
            else if (kickCnt_reg != '0)
                speed_next = SPD_FULL;
            else
                speed_next = SPD_HALF;
        end
        else
            speed_next = SPD_STOP;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            speed_reg <= SPEED_RESET;
        else if (ce)
            speed_reg <= speed_next;
    end

    // A stop cancels any pending hold so that a later restart is not stuck at full speed.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            holdCnt_reg <= '0;
        else if (ce)
        begin
            if (req.stop)
                holdCnt_reg <= '0;
            else if (loadHold)
                holdCnt_reg <= CNT_W'(HOLD_CYCLES - 1);
            else if (holdCnt_reg != '0)
                holdCnt_reg <= holdCnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            kickCnt_reg <= '0;
        else if (ce)
        begin
            if (req.stop || !req.half)
                kickCnt_reg <= '0;
            else if (loadKick)
                kickCnt_reg <= CNT_W'(KICK_LEN - 1);
            else if (kickCnt_reg != '0)
                kickCnt_reg <= kickCnt_reg - 1'b1;
        end
    end

    assign speed = speed_reg;

endmodule

/* File: bench/cfss_checker.sv */
// Checker for the fan speed selector: stop, full-speed, kick and mode relations at the top ports.
// Assumes one clock domain and fan commands registered one cycle after the flags.
`timescale 1ns/1ps
module cfss_checker
    import cfss_pkg::*;
(
    input wire logic          clk,
    input wire logic          resetn,
    input wire logic          ce,
    input wire cfss_machine_t machine,
    input wire cfss_fan_cmd_t fanCmd,
    input wire cfss_mode_t    machineMode,
    input wire logic          modeChanged
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic runReq;
    logic anyStop;
    // Standby is counted with the stops because it stops the imaging-unit fan.
    assign anyStop = |machine[14:5];
    assign runReq  = machine.warmUp | machine.initialOp | machine.imageStab | machine.printing;
    a_power_stop: assert property (ce && (machine.powerSwitchOff | machine.lowPower | machine.sleep)
        |=> fanCmd == 12'h000) else $error("power stop missed");
    a_update_stop: assert property (ce && machine.fwUpdate |=> fanCmd == 12'h000)
        else $error("update stop missed");
    a_fault_stop: assert property (ce && (machine.paperJam | machine.trouble | machine.frontDoorOpen)
        |=> fanCmd == 12'h000) else $error("fault stop missed");
    a_door_stop: assert property (ce && machine.doorOpen |=> fanCmd[1:0] == 4'h0 && fanCmd[5:4] == 4'h0)
        else $error("door stop missed");
    a_drives_stop: assert property (ce && machine.drivesOff |=> fanCmd == 12'h000)
        else $error("drives-off stop missed");
    a_run_full: assert property (ce && runReq && !anyStop |=> fanCmd == 12'hAAA)
        else $error("full speed missed");
    a_belt_full: assert property (ce && machine.beltClean && !anyStop
        |=> fanCmd[2] == SPD_FULL && fanCmd[5:4] == 4'hA) else $error("belt clean speed wrong");
    a_unit_standby: assert property (ce && machine.standby |=> fanCmd[4] == SPD_STOP)
        else $error("imaging fan not stopped");
    a_kick_first: assert property (fanCmd[2] == SPD_STOP ##1 fanCmd[2] != SPD_STOP
        |-> fanCmd[2] == SPD_FULL) else $error("start without kick");
    a_mode_pulse: assert property ($changed(machineMode) |-> modeChanged)
        else $error("mode pulse missing");
    c_all_full: cover property (fanCmd == 12'hAAA);
    c_paper_half: cover property (fanCmd[2] == SPD_HALF);
    c_rear_hold: cover property (machine.standby && fanCmd[5] == SPD_FULL);
endmodule

bind cfss_selector cfss_checker u_checker (.clk(clk), .resetn(resetn), .ce(ce), .machine(machine),
    .fanCmd(fanCmd), .machineMode(machineMode), .modeChanged(modeChanged));

/* File: bench/cfss_fan_model.sv */
// Fan driver stand-in: latches any speed code outside stop, half and full.
// Assumes commands change only on rising clock edges.
`timescale 1ns/1ps
module cfss_fan_model
    import cfss_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire cfss_fan_cmd_t fanCmd,
    output logic               badCode
);
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            badCode <= 1'b0;
        else if (fanCmd[0] == 2'h3 || fanCmd[1] == 2'h3 || fanCmd[2] == 2'h3 || fanCmd[3] == 2'h3
            || fanCmd[4] == 2'h3 || fanCmd[5] == 2'h3)
            badCode <= 1'b1;
    end
endmodule

/* File: bench/cfss_selector_tb.sv */
// Self-checking bench for the fan speed selector: steady cases from a table, then kick, hold and freeze.
// Assumes short hold and kick counts and a fan driver stand-in on the command outputs.
`timescale 1ns/1ps
module cfss_selector_tb
    import cfss_pkg::*;
();
    localparam int unsigned HL = 20;
    localparam int unsigned HS = 8;
    localparam int unsigned KL = 4;
    typedef struct packed {
        logic [14:0] m;
        logic [11:0] c;
        cfss_mode_t  md;
    } cfss_row_t;
    localparam cfss_row_t ROWS [14] = '{'{15'h0001, 12'hAAA, MODE_PRINT}, '{15'h4001, 12'h000, MODE_HALT},
        '{15'h2001, 12'h000, MODE_HALT}, '{15'h1001, 12'h000, MODE_HALT}, '{15'h0801, 12'h000, MODE_HALT},
        '{15'h0401, 12'h000, MODE_HALT}, '{15'h0201, 12'h000, MODE_HALT}, '{15'h0101, 12'h0A0, MODE_HALT},
        '{15'h0081, 12'h000, MODE_HALT}, '{15'h0041, 12'h000, MODE_HALT}, '{15'h0002, 12'hA20, MODE_BELTCLEAN},
        '{15'h0010, 12'hAAA, MODE_WARMUP}, '{15'h0008, 12'hAAA, MODE_WARMUP}, '{15'h0004, 12'hAAA, MODE_WARMUP}};
    logic          clk;
    logic          resetn;
    logic          ce;
    cfss_machine_t machine;
    cfss_fan_cmd_t fanCmd;
    cfss_mode_t    machineMode;
    logic          modeChanged;
    logic          badCode;
    logic [11:0]   expCmd;
    int            n_fail;
    int            n_compared;
    int            cycles = 0;
    cfss_selector #(.HOLD_LONG(HL), .HOLD_SHORT(HS), .KICK_LEN(KL)) dut (.clk(clk), .resetn(resetn), .ce(ce),
        .machine(machine), .fanCmd(fanCmd), .machineMode(machineMode), .modeChanged(modeChanged));
    cfss_fan_model u_fan (.clk(clk), .resetn(resetn), .fanCmd(fanCmd), .badCode(badCode));
    task automatic cmp_cmd(string what, logic [11:0] e);
        n_compared++;
        if (fanCmd !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, fanCmd);
        end
    endtask
    task automatic cmp_val(string what, logic [2:0] e, logic [2:0] s);
        n_compared++;
        if (s !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic apply(logic [14:0] m);
        @(posedge clk);
        machine <= m;
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // The ceiling is far above the 85 or so cycles the tests need, so only a hang reaches it.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 1000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial
    begin
        resetn = 1'b0;
        ce = 1'b1;
        machine = '0;
        n_fail = 0;
        n_compared = 0;
        settle(3);
        cmp_cmd("reset command", 12'h000);
        cmp_val("reset mode", MODE_HALT, machineMode);
        cmp_val("reset pulse", 3'h0, {2'h0, modeChanged});
        @(posedge clk);
        resetn <= 1'b1;
        $display("Test reset done");
        for (int r = 0; r < 14; r++)
        begin
            apply(ROWS[r].m);
            settle(2);
            cmp_cmd("table command", ROWS[r].c);
            cmp_val("table mode", ROWS[r].md, machineMode);
        end
        $display("Test table done");
        apply(15'h1000);
        apply(15'h0020);
        for (int k = 1; k <= KL + 1; k++)
        begin
            settle(1);
            cmp_cmd("kick command", (k <= KL) ? 12'h0AA : 12'h055);
        end
        $display("Test kick done");
        apply(15'h0001);
        settle(2);
        cmp_cmd("print over half", 12'hAAA);
        apply(15'h0020);
        for (int k = 1; k <= HL + 1; k++)
        begin
            settle(1);
            expCmd = {(k <= HL) ? 2'h2 : 2'h0, 2'h0, (k <= HL) ? 2'h2 : 2'h1, 2'h1, (k <= HS) ? 4'hA : 4'h5};
            cmp_cmd("hold command", expCmd);
            if (k == 1)
                cmp_val("mode pulse", 3'h1, {2'h0, modeChanged});
        end
        $display("Test hold done");
        @(posedge clk);
        ce <= 1'b0;
        machine <= 15'h1000;
        settle(3);
        cmp_cmd("frozen command", 12'h055);
        @(posedge clk);
        ce <= 1'b1;
        settle(2);
        cmp_cmd("sleep after freeze", 12'h000);
        cmp_val("driver code", 3'h0, {2'h0, badCode});
        $display("Test freeze done");
        tally_and_finish();
    end
endmodule
